// >>> rtl/irq_pwr_dev.sv
// device end: interrupt gating, power-on reset, clock wake, pull-up control
// assumes event pulses, register writes and supply comparator from surrounding core
// Behaviour
// RQ1 - level mode, gate off: latch, pin idle
// RQ2 - gate on with pending status asserts pin
// RQ3 - gate off keeps asserted pin active
// RQ4 - pin drops only when sources cleared
// RQ5 - host writes every status byte when clearing
// RQ6 - suspended clock-off restarts on vbus detect
// RQ7 - external reset held at least 500 us
// RQ8 - strapped reset gives internal 200 ns pulse
// RQ9 - reset stays high one stretch after trip
// RQ10 - dips over 11 us re-trigger reset
// RQ11 - power-sharing host resets at least 2 ms
// RQ12 - cable removed: clear connect bit, drop pull-up; device drops pull-up with vbus, connect bit held until a cfg write
// RQ13 - pulse mode: 60 ns on rising pending
// RQ14 - reset default active low, level mode
// RQ15 - per-source enables gate latched events
//
// Added by the designer: the strobed register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module irq_pwr_dev
  import irq_pwr_pkg::*;
#(
  parameter int unsigned DIP_CYC   = DIP_MIN_CYC,
  parameter int unsigned PULSE_CYC = POR_PULSE_CYC
) (
  input  wire logic             clock_i,
  input  wire logic             rst_n_i,
  input  wire logic             clk_en_i,
  irq_pwr_if.dev                pins,
  input  wire logic [USB_W-1:0] usb_event_i,
  input  wire logic [DMA_W-1:0] dma_event_i,
  input  wire logic [USB_W-1:0] usb_enable_i,
  input  wire logic [DMA_W-1:0] dma_enable_i,
  input  wire logic             usb_clear_we_i,
  input  wire logic [USB_W-1:0] usb_clear_i,
  input  wire logic             dma_clear_we_i,
  input  wire logic [DMA_W-1:0] dma_clear_i,
  input  wire logic             cfg_we_i,
  input  wire logic             global_irq_enable_i,
  input  wire logic             irq_polarity_sel_i,
  input  wire logic             irq_signalling_sel_i,
  input  wire logic             clock_always_on_bit_i,
  input  wire logic             pullup_connect_bit_i,
  input  wire logic             suspend_i,
  input  wire logic             vbus_sense_i,
  input  wire logic             supply_ok_i,
  output logic [USB_W-1:0]      usb_status_o,
  output logic [DMA_W-1:0]      dma_status_o,
  output logic                  core_reset_o,
  output logic                  core_clk_run_o,
  output logic                  pullup_on_o,
  output logic                  vbus_o
);
  logic [USB_W-1:0] usb_q;
  logic [DMA_W-1:0] dma_q;
  logic             glint_q, pol_q, lvl_q, clock_always_on_bit_q, connect_q;
  logic             any_d, any_q, asserted_q, pin_q;
  logic [7:0]       pulse_cnt_q;
  logic [2:0]       vbus_s_q, sup_s_q, rst_s_q;
  logic             vbus_f_q, sup_f_q, ext_rst_f_q;
  logic [31:0]      dip_cnt_q, stretch_cnt_q;
  logic             por_q, clk_run_q;

  // sticky status; a new event beats a simultaneous clear
  always_ff @(posedge clock_i) begin
    if (!rst_n_i || por_q) begin
      usb_q <= '0;
      dma_q <= '0;
    end else if (clk_en_i) begin
      usb_q <= (usb_q & ~(usb_clear_we_i ? usb_clear_i : '0)) | usb_event_i; // [RQ1] [RQ5]
      dma_q <= (dma_q & ~(dma_clear_we_i ? dma_clear_i : '0)) | dma_event_i;
    end
  end

  // configuration bits; defaults active low and level signalling
  always_ff @(posedge clock_i) begin
    if (!rst_n_i || por_q) begin
      glint_q   <= 1'b0;
      pol_q     <= 1'b0; // [RQ14]
      lvl_q     <= 1'b1; // [RQ14]
      clock_always_on_bit_q  <= 1'b0;
      connect_q <= 1'b0;
    end else if (clk_en_i && cfg_we_i) begin
      glint_q   <= global_irq_enable_i;
      pol_q     <= irq_polarity_sel_i;
      lvl_q     <= irq_signalling_sel_i;
      clock_always_on_bit_q  <= clock_always_on_bit_i;
      connect_q <= pullup_connect_bit_i;
    end
  end

  // or of enabled pending sources
  always_comb begin
    any_d = |(usb_q & usb_enable_i) | |(dma_q & dma_enable_i); // [RQ15]
  end

  // interrupt pin: level latch keeps asserting once the gate opened
  always_ff @(posedge clock_i) begin
    if (!rst_n_i || por_q) begin
      any_q       <= 1'b0;
      asserted_q  <= 1'b0;
      pulse_cnt_q <= '0;
    end else if (clk_en_i) begin
      any_q <= any_d;
      if (!any_d)
        asserted_q <= 1'b0; // [RQ4]
      else if (glint_q)
        asserted_q <= 1'b1; // [RQ2] [RQ3]
      if (glint_q && any_d && !any_q)
        pulse_cnt_q <= 8'(IRQ_PULSE_CYC); // [RQ13]
      else if (pulse_cnt_q != '0)
        pulse_cnt_q <= pulse_cnt_q - 8'h01;
    end
  end

  // pin driven from a flip-flop, polarity applied last
  always_ff @(posedge clock_i) begin
    if (!rst_n_i)
      pin_q <= 1'b1;
    else if (clk_en_i)
      pin_q <= (lvl_q ? asserted_q : (pulse_cnt_q != '0)) ^ ~pol_q; // [RQ1] [RQ13]
  end
  assign pins.irq_pin = pin_q;

  // three-stage synchronisers for pins from outside
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      vbus_s_q <= '0;
      sup_s_q  <= '0;
      rst_s_q  <= 3'h7;
      vbus_f_q <= 1'b0;
      sup_f_q  <= 1'b0;
      ext_rst_f_q <= 1'b1;
    end else if (clk_en_i) begin
      vbus_s_q <= {vbus_s_q[1:0], vbus_sense_i};
      sup_s_q  <= {sup_s_q[1:0], supply_ok_i};
      rst_s_q  <= {rst_s_q[1:0], pins.reset_pin_n};
      if (vbus_s_q[1] == vbus_s_q[2]) vbus_f_q <= vbus_s_q[2];
      if (sup_s_q[1] == sup_s_q[2]) sup_f_q <= sup_s_q[2];
      if (rst_s_q[1] == rst_s_q[2]) ext_rst_f_q <= rst_s_q[2];
    end
  end

  // power-on reset: dip filter then stretch after the trip level
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      por_q         <= 1'b1;
      dip_cnt_q     <= '0;
      stretch_cnt_q <= '0;
    end else if (clk_en_i) begin
      if (!pins.reset_tied) begin
        por_q <= ~ext_rst_f_q; // [RQ7]
      end else if (!sup_f_q) begin
        stretch_cnt_q <= '0;
        if (dip_cnt_q < DIP_CYC)
          dip_cnt_q <= dip_cnt_q + 32'h1;
        else
          por_q <= 1'b1; // [RQ10]
      end else begin
        dip_cnt_q <= '0;
        if (por_q) begin
          if (stretch_cnt_q + 32'h1 >= PULSE_CYC)
            por_q <= 1'b0; // [RQ8] [RQ9]
          else
            stretch_cnt_q <= stretch_cnt_q + 32'h1;
        end
      end
    end
  end
  assign core_reset_o = por_q;

  // clock gating during suspend; vbus wakes a stopped clock
  always_ff @(posedge clock_i) begin
    if (!rst_n_i)
      clk_run_q <= 1'b1;
    else if (clk_en_i) begin
      if (!suspend_i || clock_always_on_bit_q || vbus_f_q) // filtered vbus level keeps the clock up, no toggling
        clk_run_q <= 1'b1; // [RQ6]
      else
        clk_run_q <= 1'b0;
    end
  end
  assign core_clk_run_o = clk_run_q;

  // pull-up only while connect bit is set and vbus present
  assign pullup_on_o  = connect_q && vbus_f_q; // [RQ12]
  assign vbus_o       = vbus_f_q;
  assign usb_status_o = usb_q;
  assign dma_status_o = dma_q;
endmodule
`default_nettype wire

// >>> rtl/irq_pwr_pkg.sv
// shared constants for the interrupt gate and power/reset sequencer pair
// assumes a single 250 MHz clock shared by both ends
package irq_pwr_pkg;
  localparam int unsigned CLK_MHZ          = 250;
  localparam int unsigned POR_PULSE_NS     = 200;
  localparam int unsigned POR_PULSE_CYC    = (POR_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned DIP_MIN_US       = 11;
  localparam int unsigned DIP_MIN_CYC      = DIP_MIN_US * CLK_MHZ;
  localparam int unsigned IRQ_PULSE_NS     = 60;
  localparam int unsigned IRQ_PULSE_CYC    = (IRQ_PULSE_NS * CLK_MHZ) / 1000;
  localparam int unsigned EXT_RST_US       = 500;
  localparam int unsigned EXT_RST_CYC      = EXT_RST_US * CLK_MHZ;
  localparam int unsigned SHARE_RST_MS     = 2;
  localparam int unsigned SHARE_RST_CYC    = SHARE_RST_MS * 1000 * CLK_MHZ;
  localparam int unsigned USB_W            = 32;
  localparam int unsigned DMA_W            = 16;
  // controller register offsets
  localparam logic [3:0] A_CTRL     = 4'h0;
  localparam logic [3:0] A_STATUS   = 4'h1;
  localparam logic [3:0] A_CLEAR    = 4'h2;
  localparam logic [3:0] A_ENABLE   = 4'h3;
  localparam logic [3:0] A_RST_LEN  = 4'h4;
  // controller status / enable bit positions
  localparam int unsigned EV_IRQ    = 0;
  localparam int unsigned EV_RSTDN  = 1;
  localparam int unsigned EV_VBUSOFF = 2;
  localparam int unsigned NEV       = 3;
  // controller control bit positions
  localparam int unsigned C_RST_GO  = 0;
  localparam int unsigned C_SHARE   = 1;
  localparam logic [31:0] RST_LEN_RESET = 32'h0001_e848; // 125000 cycles
endpackage

// >>> rtl/irq_pwr_if.sv
// pins between the peripheral's interrupt/power block and the system controller
// assumes the testbench resolves nothing: all pins are one-way
`timescale 1ns/1ps
`default_nettype none
interface irq_pwr_if;
  logic irq_pin;      // interrupt pin, polarity per configuration
  logic reset_pin_n;  // external reset, active low, driven by controller
  logic reset_tied;   // high when reset pin strapped to supply
  modport dev (output irq_pin, input reset_pin_n, input reset_tied);
  modport host (input irq_pin, output reset_pin_n, output reset_tied);
endinterface
`default_nettype wire

// >>> rtl/irq_pwr_host.sv
// system controller end: drives reset, watches interrupt pin, pulses connect_clear_o when vbus drops
// assumes a simple register port from software, read data one cycle later
`timescale 1ns/1ps
`default_nettype none
module irq_pwr_host
  import irq_pwr_pkg::*;
(
  input  wire logic        clock_i,
  input  wire logic        rst_n_i,
  input  wire logic        clk_en_i,
  irq_pwr_if.host          pins,
  input  wire logic        strap_tied_i,
  input  wire logic        vbus_i,
  input  wire logic [3:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic [31:0]      rdata_o,
  output logic             connect_clear_o,
  output logic             irq_o
);
  logic [NEV-1:0] stat_q, en_q, ev;
  logic [31:0]    len_q, cnt_q, rdata_q;
  logic [2:0]     pin_s_q;
  logic           pin_f_q, pin_prev_q, rst_q, share_q, vbus_prev_q, clr_q;

  function automatic logic min_ok(input logic [31:0] v, input logic share);
    min_ok = v >= (share ? SHARE_RST_CYC : EXT_RST_CYC);
  endfunction

  // reset pulse generator, length never below the minimum
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      rst_q   <= 1'b0;
      cnt_q   <= '0;
      len_q   <= RST_LEN_RESET;
      share_q <= 1'b0;
    end else if (clk_en_i) begin
      if (wr_i && addr_i == A_RST_LEN) len_q <= wdata_i;
      if (wr_i && addr_i == A_CTRL) begin
        share_q <= wdata_i[C_SHARE];
        if (wdata_i[C_RST_GO]) begin
          rst_q <= 1'b1;
          cnt_q <= '0;
        end
      end else if (rst_q) begin
        cnt_q <= cnt_q + 32'h1;
        if (cnt_q + 32'h1 >= len_q && min_ok(cnt_q + 32'h1, share_q))
          rst_q <= 1'b0; // [RQ7] [RQ11]
      end
    end
  end
  assign pins.reset_pin_n = ~rst_q;
  assign pins.reset_tied  = strap_tied_i;

  // interrupt pin synchroniser, active level taken as low
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      pin_s_q <= 3'h7;
      pin_f_q <= 1'b1;
      pin_prev_q <= 1'b1;
      vbus_prev_q <= 1'b0;
      clr_q <= 1'b0;
    end else if (clk_en_i) begin
      pin_s_q <= {pin_s_q[1:0], pins.irq_pin};
      if (pin_s_q[1] == pin_s_q[2]) pin_f_q <= pin_s_q[2];
      pin_prev_q <= pin_f_q;
      vbus_prev_q <= vbus_i;
      clr_q <= vbus_prev_q && !vbus_i; // [RQ12]
    end
  end
  assign connect_clear_o = clr_q;

  // events: device interrupt, reset finished, cable removed
  always_comb begin
    ev = '0;
    ev[EV_IRQ]     = pin_prev_q && !pin_f_q;
    ev[EV_RSTDN]   = clk_en_i && rst_q && !(wr_i && addr_i == A_CTRL) && cnt_q + 32'h1 >= len_q
                     && min_ok(cnt_q + 32'h1, share_q);
    ev[EV_VBUSOFF] = clr_q;
  end

  // sticky status, set beats clear
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      stat_q <= '0;
      en_q   <= '0;
    end else if (clk_en_i) begin
      if (wr_i && addr_i == A_ENABLE) en_q <= wdata_i[NEV-1:0];
      stat_q <= (stat_q & ~((wr_i && addr_i == A_CLEAR) ? wdata_i[NEV-1:0] : '0)) | ev;
    end
  end
  assign irq_o = |(stat_q & en_q);

  // read port, data one cycle after strobe
  always_ff @(posedge clock_i) begin
    if (!rst_n_i)
      rdata_q <= '0;
    else if (clk_en_i && rd_i) begin
      case (addr_i)
        A_CTRL:    rdata_q <= {30'h0, share_q, rst_q};
        A_STATUS:  rdata_q <= {29'h0, stat_q};
        A_ENABLE:  rdata_q <= {29'h0, en_q};
        A_RST_LEN: rdata_q <= len_q;
        default:   rdata_q <= '0;
      endcase
    end else
      rdata_q <= '0;
  end
  assign rdata_o = rdata_q;
endmodule
`default_nettype wire

// >>> bench/irq_pwr_props.sv
// checker on the pins joining the two ends and on the device's status and power outputs
// assumes one clock and a synchronous active-low reset shared by both ends
`timescale 1ns/1ps
`default_nettype none
module irq_pwr_props
  import irq_pwr_pkg::*;
#(
  parameter int unsigned DIP_CYC   = DIP_MIN_CYC,
  parameter int unsigned PULSE_CYC = POR_PULSE_CYC
) (
  input wire logic             clock_i,
  input wire logic             rst_n_i,
  input wire logic             irq_pin,
  input wire logic             reset_pin_n,
  input wire logic             reset_tied,
  input wire logic [USB_W-1:0] usb_status_o,
  input wire logic [DMA_W-1:0] dma_status_o,
  input wire logic             usb_clear_we_i,
  input wire logic             dma_clear_we_i,
  input wire logic             cfg_we_i,
  input wire logic             supply_ok_i,
  input wire logic             core_reset_o,
  input wire logic             core_clk_run_o,
  input wire logic             vbus_o,
  input wire logic             pullup_on_o
);
  logic [31:0] low_q, hi_q, dip_q, quiet_q;
  // run lengths: reset pin low, supply good, supply bad, nothing pending
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      low_q   <= 32'h0;
      hi_q    <= 32'h0;
      dip_q   <= 32'h0;
      quiet_q <= 32'h0;
    end else begin
      low_q   <= reset_pin_n ? 32'h0 : low_q + 32'h1;
      hi_q    <= supply_ok_i ? hi_q + 32'h1 : 32'h0;
      dip_q   <= supply_ok_i ? 32'h0 : dip_q + 32'h1;
      quiet_q <= (|{usb_status_o, dma_status_o, cfg_we_i, core_reset_o}) ? 32'h0 : quiet_q + 32'h1;
    end
  end
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  AST_EXT_RST_MIN: assert property ($rose(reset_pin_n) |-> low_q >= EXT_RST_CYC)
    else $error("external reset pulse too short");
  AST_PIN_RST_CORE: assert property ((!reset_tied && !reset_pin_n) [*8] |-> core_reset_o)
    else $error("core reset not following reset pin");
  // thresholds include the four cycles of the supply input filter
  AST_POR_STRETCH: assert property ($fell(core_reset_o) && reset_tied |-> hi_q >= PULSE_CYC + 4)
    else $error("internal reset dropped before stretch");
  AST_DIP_FILTER: assert property ($rose(core_reset_o) && reset_tied |-> dip_q >= DIP_CYC + 4)
    else $error("internal reset on short dip");
  AST_USB_STICKY: assert property (!usb_clear_we_i |=> core_reset_o || (usb_status_o & $past(usb_status_o)) == $past(usb_status_o))
    else $error("usb status bit lost without clear");
  AST_DMA_STICKY: assert property (!dma_clear_we_i |=> core_reset_o || (dma_status_o & $past(dma_status_o)) == $past(dma_status_o))
    else $error("dma status bit lost without clear");
  AST_PIN_QUIET: assert property (quiet_q >= 32'h14 |-> $stable(irq_pin))
    else $error("interrupt pin moved with nothing pending");
  AST_CLK_WAKE: assert property (vbus_o [*2] |-> core_clk_run_o)
    else $error("clock not running with vbus present");
  AST_PULLUP_OFF: assert property (!vbus_o [*2] |-> !pullup_on_o)
    else $error("pull-up kept without vbus");
  // main scenarios
  cover property ($rose(core_reset_o));
  cover property ($fell(irq_pin));
  cover property (vbus_o ##1 !vbus_o);
endmodule
`default_nettype wire

// >>> bench/irq_gate_and_power_reset_tb.sv
// self-checking bench: device and controller ends joined by the pin interface
// assumes small filter and stretch counts for the device to keep the run short
`timescale 1ns/1ps
`default_nettype none
module irq_gate_and_power_reset_tb;
  import irq_pwr_pkg::*;
  logic              clock_i, rst_n_i, clk_en_i, usb_clear_we_i, dma_clear_we_i, cfg_we_i, wr_i, rd_i;
  logic              global_irq_enable_i, irq_polarity_sel_i, irq_signalling_sel_i, clock_always_on_bit_i;
  logic              pullup_connect_bit_i, suspend_i, vbus_sense_i, supply_ok_i, strap_tied_i;
  logic              core_reset_o, core_clk_run_o, pullup_on_o, vbus_o, connect_clear_o, irq_o;
  logic [USB_W-1:0]  usb_event_i, usb_enable_i, usb_clear_i, usb_status_o;
  logic [DMA_W-1:0]  dma_event_i, dma_enable_i, dma_clear_i, dma_status_o;
  logic [3:0]        addr_i;
  logic [31:0]       wdata_i, rdata_o, pin32, rst32, d;
  int                n_mismatch, checks_done, n;
  irq_pwr_if irq_pwr_if_inst ();
  assign pin32 = {31'h0, irq_pwr_if_inst.irq_pin};
  assign rst32 = {31'h0, irq_pwr_if_inst.reset_pin_n};
  irq_pwr_dev #(.DIP_CYC(8), .PULSE_CYC(4)) irq_pwr_dev_inst (.clock_i, .rst_n_i, .clk_en_i,
    .pins(irq_pwr_if_inst.dev), .usb_event_i, .dma_event_i, .usb_enable_i, .dma_enable_i, .usb_clear_we_i,
    .usb_clear_i, .dma_clear_we_i, .dma_clear_i, .cfg_we_i, .global_irq_enable_i, .irq_polarity_sel_i,
    .irq_signalling_sel_i, .clock_always_on_bit_i, .pullup_connect_bit_i, .suspend_i, .vbus_sense_i,
    .supply_ok_i, .usb_status_o, .dma_status_o, .core_reset_o, .core_clk_run_o, .pullup_on_o, .vbus_o);
  irq_pwr_host irq_pwr_host_inst (.clock_i, .rst_n_i, .clk_en_i, .pins(irq_pwr_if_inst.host),
    .strap_tied_i, .vbus_i(vbus_sense_i), .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .connect_clear_o, .irq_o);
  irq_pwr_props #(.DIP_CYC(8), .PULSE_CYC(4)) irq_pwr_props_inst (.clock_i, .rst_n_i,
    .irq_pin(irq_pwr_if_inst.irq_pin), .reset_pin_n(irq_pwr_if_inst.reset_pin_n),
    .reset_tied(irq_pwr_if_inst.reset_tied), .usb_status_o, .dma_status_o, .usb_clear_we_i, .dma_clear_we_i,
    .cfg_we_i, .supply_ok_i, .core_reset_o, .core_clk_run_o, .vbus_o, .pullup_on_o);
  // clock and hang guard
  initial begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end
  initial begin
    repeat (10000) @(posedge clock_i);
    n_mismatch++;
    summarize();
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // wait k edges, then settle on the falling edge
  task automatic cyc(input int k);
    repeat (k) @(posedge clock_i);
    @(negedge clock_i);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clock_i);
    addr_i  <= a;
    wdata_i <= v;
    wr_i    <= 1'b1;
    @(posedge clock_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge clock_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clock_i);
    rd_i <= 1'b0;
    @(negedge clock_i);
    v = rdata_o;
  endtask
  // bits: gate, polarity, level mode, clock always on, pull-up connect
  task automatic cfg(input logic [4:0] v);
    @(posedge clock_i);
    {global_irq_enable_i, irq_polarity_sel_i, irq_signalling_sel_i, clock_always_on_bit_i, pullup_connect_bit_i} <= v;
    cfg_we_i <= 1'b1;
    @(posedge clock_i);
    cfg_we_i <= 1'b0;
  endtask
  // one-cycle event pulse, or clear of the bits set in u and m when c is set
  task automatic pend(input logic c, input logic [31:0] u, input logic [15:0] m);
    @(posedge clock_i);
    {usb_event_i, dma_event_i} <= c ? 48'h0 : {u, m};
    {usb_clear_i, dma_clear_i, usb_clear_we_i, dma_clear_we_i} <= {u, m, c, c};
    @(posedge clock_i);
    {usb_event_i, dma_event_i, usb_clear_we_i, dma_clear_we_i} <= '0;
  endtask
  task automatic wcore(input logic v);
    for (int i = 0; i < 60 && core_reset_o !== v; i++) @(negedge clock_i);
    chk("core_reset_o", {31'h0, v}, {31'h0, core_reset_o});
  endtask
  initial begin
    {rst_n_i, usb_clear_we_i, dma_clear_we_i, cfg_we_i, wr_i, rd_i, global_irq_enable_i} = '0;
    {irq_polarity_sel_i, irq_signalling_sel_i, clock_always_on_bit_i, pullup_connect_bit_i} = 4'h2;
    {suspend_i, vbus_sense_i, usb_event_i, dma_event_i, usb_clear_i, dma_clear_i, addr_i, wdata_i} = '0;
    {clk_en_i, supply_ok_i, strap_tied_i, usb_enable_i, dma_enable_i} = '1;
    repeat (12) @(posedge clock_i);
    rst_n_i <= 1'b1;
    wcore(1'b0);
    chk("irq_pin idle", 32'h1, pin32);
    cfg(5'b00100);
    pend(1'b0, 32'h20, 16'h4);
    cyc(3);
    chk("usb_status_o", 32'h20, usb_status_o);
    chk("irq_pin gated", 32'h1, pin32);
    cfg(5'b10100);
    cyc(3);
    chk("irq_pin gate on", 32'h0, pin32);
    cfg(5'b00100);
    cyc(4);
    chk("irq_pin gate off", 32'h0, pin32);
    pend(1'b1, 32'hffff_ffff, 16'h0);
    cyc(4);
    chk("irq_pin dma left", 32'h0, pin32);
    pend(1'b1, 32'h0, 16'hffff);
    cyc(3);
    chk("irq_pin all clear", 32'h1, pin32);
    $display("test gate done");
    // frozen clock enable: an event and a register write must both be lost
    @(posedge clock_i);
    clk_en_i <= 1'b0;
    pend(1'b0, 32'h2, 16'h0);
    wr(A_ENABLE, 32'h7);
    clk_en_i <= 1'b1;
    cyc(2);
    chk("frozen status", 32'h0, usb_status_o);
    rd(A_ENABLE, d);
    chk("frozen enable", 32'h0, d);
    $display("test clock enable done");
    cfg(5'b10100);
    @(posedge clock_i);
    usb_enable_i <= 32'hffff_ff7f;
    pend(1'b0, 32'h80, 16'h0);
    cyc(4);
    chk("usb_status_o masked", 32'h80, usb_status_o);
    chk("irq_pin masked", 32'h1, pin32);
    pend(1'b1, 32'hffff_ffff, 16'hffff);
    cfg(5'b11000);
    cyc(3);
    chk("irq_pin high idle", 32'h0, pin32);
    pend(1'b0, 32'h1, 16'h0);
    n = 0;
    repeat (40) begin
      @(negedge clock_i);
      if (irq_pwr_if_inst.irq_pin === 1'b1) n++;
    end
    chk("pulse width", IRQ_PULSE_CYC, n);
    pend(1'b1, 32'hffff_ffff, 16'hffff);
    $display("test mask and pulse done");
    cfg(5'b00101);
    @(posedge clock_i);
    suspend_i    <= 1'b1;
    vbus_sense_i <= 1'b1;
    cyc(10);
    chk("pullup_on_o", 32'h1, {31'h0, pullup_on_o});
    @(posedge clock_i);
    vbus_sense_i <= 1'b0;
    n = 0;
    repeat (12) begin
      @(negedge clock_i);
      if (connect_clear_o === 1'b1) n++;
    end
    chk("connect_clear_o", 32'h1, n);
    chk("pullup off", 32'h0, {31'h0, pullup_on_o});
    chk("clock stopped", 32'h0, {31'h0, core_clk_run_o});
    cfg(5'b00100);
    rd(A_STATUS, d);
    chk("vbus lost", 32'h4, d & 32'h4);
    chk("irq_o masked", 32'h0, {31'h0, irq_o});
    wr(A_ENABLE, 32'h4);
    cyc(2);
    chk("irq_o", 32'h1, {31'h0, irq_o});
    wr(A_CLEAR, 32'h4);
    cyc(2);
    chk("irq_o cleared", 32'h0, {31'h0, irq_o});
    @(posedge clock_i);
    vbus_sense_i <= 1'b1;
    cyc(10);
    chk("clock woken", 32'h1, {31'h0, core_clk_run_o});
    chk("pullup stays off", 32'h0, {31'h0, pullup_on_o});
    $display("test vbus done");
    pend(1'b0, 32'h1, 16'h0);
    @(posedge clock_i);
    supply_ok_i <= 1'b0;
    repeat (6) @(posedge clock_i);
    supply_ok_i <= 1'b1;
    cyc(20);
    chk("short dip", 32'h0, {31'h0, core_reset_o});
    @(posedge clock_i);
    supply_ok_i <= 1'b0;
    cyc(20);
    wcore(1'b1);
    @(posedge clock_i);
    supply_ok_i <= 1'b1;
    cyc(2);
    chk("stretch", 32'h1, {31'h0, core_reset_o});
    wcore(1'b0);
    chk("status after por", 32'h0, usb_status_o);
    $display("test power-on reset done");
    @(posedge clock_i);
    strap_tied_i <= 1'b0;
    rd(A_RST_LEN, d);
    chk("rst_len reset", RST_LEN_RESET, d);
    wr(A_RST_LEN, 32'ha);
    rd(A_RST_LEN, d);
    chk("rst_len", 32'ha, d);
    rd(4'hf, d);
    chk("unmapped", 32'h0, d);
    wr(A_CTRL, 32'h1);
    cyc(0);
    chk("reset_pin_n", 32'h0, rst32);
    cyc(1000);
    chk("reset held", 32'h0, rst32);
    chk("core reset", 32'h1, {31'h0, core_reset_o});
    wr(A_CTRL, 32'h3);
    cyc(2000);
    chk("share reset held", 32'h0, rst32);
    rd(A_CTRL, d);
    chk("share mode", 32'h3, d);
    $display("test external reset done");
    summarize();
  end
endmodule
`default_nettype wire
